// ### src/auxreg_pkg.sv
package auxreg_pkg;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFF_HARDWARE_CONTROL_REG = 8'h04;
  localparam logic [7:0] OFF_SUP_STAT_2 = 8'h08;
  localparam logic [7:0] OFF_CFG_STAT = 8'h0c;
  // Mode control fields
  localparam int MC_STANDALONE = 0;
  localparam int MC_VSEL = 1;
  // Hardware control fields
  localparam int HC_SHARE = 0;
  localparam int HC_KEEP_STOP = 1;
  localparam int HC_KEEP_OFF_UV = 2;
  // Supply status 2 fields
  localparam int SS_OC = 0;
  localparam int SS_UV = 1;
  localparam int SS_ON = 2;
  localparam int SS_HP = 3;
  localparam int SS_LP = 4;
  localparam int SS_OFF_UV = 5;
  // Configuration status fields
  localparam int CS_SA = 0;
  localparam int CS_LS = 1;
  localparam int CS_FAIL = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic hresp_okay = 1'b0;

  typedef enum logic [2:0] {
    AUXRG_MD_INIT = 3'h0,
    AUXRG_MD_NORMAL = 3'h1,
    AUXRG_MD_STOP = 3'h2,
    AUXRG_MD_SLEEP = 3'h3,
    AUXRG_MD_RESTART = 3'h4,
    AUXRG_MD_FAILSAFE = 3'h5
  } auxrg_mode_e;

  typedef enum logic [2:0] {
    AUXRG_CFG_NONE = 3'b001,
    AUXRG_CFG_SA = 3'b010,
    AUXRG_CFG_LS = 3'b100
  } auxrg_cfg_e;

  // Analog-side condition inputs
  typedef struct packed {
    logic main_on;
    logic main_3v3;
    logic battery_uv;
    logic shunt_limit;
    logic out_uv;
    logic base_above_rise;
    logic base_below_fall;
  } auxrg_sense_s;

  // Regulator control outputs
  typedef struct packed {
    logic aux_on;
    logic vsel_1v8;
    logic hp_stage;
    logic lp_stage;
  } auxrg_drive_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } auxrg_aphase_s;
endpackage : auxreg_pkg

// ### src/auxrg_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module auxrg_ctrl #(
  parameter int HADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic soft_reset,
  input wire auxreg_pkg::auxrg_mode_e sbc_mode,
  input wire auxreg_pkg::auxrg_sense_s sense,
  output auxreg_pkg::auxrg_drive_s drive,
  output logic access_fail
);
  import auxreg_pkg::*;

  if (HADDR_W < 8) begin : g_bad_width
    $error("HADDR_W must be at least 8");
  end

  // Bus address phase
  auxrg_aphase_s aph_r, aph_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take;

  // Control and status state
  auxrg_cfg_e cfg_r, cfg_nxt;
  logic sa_bit_r, sa_bit_nxt;
  logic vsel_bit_r, vsel_bit_nxt;
  logic share_bit_r, share_bit_nxt;
  logic keep_stop_r, keep_stop_nxt;
  logic keep_off_r, keep_off_nxt;
  logic oc_flag_r, oc_flag_nxt;
  logic uv_flag_r, uv_flag_nxt;
  logic fail_r, fail_nxt;
  logic uv_hold_r, uv_hold_nxt;
  logic hp_stop_r, hp_stop_nxt;
  auxrg_drive_s drive_r, drive_nxt;

  logic wr_mc, wr_hc, wr_ss, wr_cs;
  logic want_on;

  function automatic logic hit(input auxrg_aphase_s a, input logic [7:0] off);
    hit = a.valid && a.write && (a.addr == off);
  endfunction : hit

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = hresp_okay;
  assign hrdata = rdata_r;
  assign drive = drive_r;
  assign access_fail = fail_r;

  assign wr_mc = hit(aph_r, OFF_MODE_CTRL);
  assign wr_hc = hit(aph_r, OFF_HARDWARE_CONTROL_REG);
  assign wr_ss = hit(aph_r, OFF_SUP_STAT_2);
  assign wr_cs = hit(aph_r, OFF_CFG_STAT);

  always_comb begin
    aph_nxt.valid = take;
    aph_nxt.write = hwrite;
    aph_nxt.addr = {haddr[7:2], 2'b00};
    rdata_nxt = rdata_r;
    if (take && !hwrite) begin
      rdata_nxt = RESET_WORD;
      case ({haddr[7:2], 2'b00})
        OFF_MODE_CTRL: begin
          rdata_nxt[MC_STANDALONE] = sa_bit_r;
          rdata_nxt[MC_VSEL] = vsel_bit_r;
        end
        OFF_HARDWARE_CONTROL_REG: begin
          rdata_nxt[HC_SHARE] = share_bit_r;
          rdata_nxt[HC_KEEP_STOP] = keep_stop_r;
          rdata_nxt[HC_KEEP_OFF_UV] = keep_off_r;
        end
        OFF_SUP_STAT_2: begin
          rdata_nxt[SS_OC] = oc_flag_r;
          rdata_nxt[SS_UV] = uv_flag_r;
          rdata_nxt[SS_ON] = drive_r.aux_on;
          rdata_nxt[SS_HP] = drive_r.hp_stage;
          rdata_nxt[SS_LP] = drive_r.lp_stage;
          rdata_nxt[SS_OFF_UV] = uv_hold_r;
        end
        OFF_CFG_STAT: begin
          rdata_nxt[CS_SA] = (cfg_r == AUXRG_CFG_SA);
          rdata_nxt[CS_LS] = (cfg_r == AUXRG_CFG_LS);
          rdata_nxt[CS_FAIL] = fail_r;
        end
        default: rdata_nxt = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r <= '0;
      rdata_r <= RESET_WORD;
    end else begin
      aph_r <= aph_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Configuration lock and control bits; soft reset never touches cfg_r
  always_comb begin
    cfg_nxt = cfg_r;
    sa_bit_nxt = sa_bit_r;
    vsel_bit_nxt = vsel_bit_r;
    share_bit_nxt = share_bit_r;
    keep_stop_nxt = keep_stop_r;
    keep_off_nxt = keep_off_r;
    fail_nxt = fail_r;
    if (wr_cs && hwdata[CS_FAIL]) begin
      fail_nxt = 1'b0;
    end
    case (cfg_r)
      AUXRG_CFG_NONE: begin
        if (wr_hc && hwdata[HC_SHARE] && sbc_mode == AUXRG_MD_NORMAL) begin
          cfg_nxt = AUXRG_CFG_LS;
          share_bit_nxt = 1'b1;
        end else if (wr_mc && hwdata[MC_STANDALONE] && sbc_mode == AUXRG_MD_NORMAL) begin
          cfg_nxt = AUXRG_CFG_SA;
          sa_bit_nxt = 1'b1;
        end
      end
      AUXRG_CFG_SA: begin
        // Switching stays free; share requests are dropped silently
        if (wr_mc) begin
          sa_bit_nxt = hwdata[MC_STANDALONE];
        end
      end
      AUXRG_CFG_LS: begin
        if ((wr_mc && hwdata[MC_STANDALONE]) || (wr_hc && !hwdata[HC_SHARE])) begin
          fail_nxt = 1'b1;
        end
      end
      default: cfg_nxt = AUXRG_CFG_NONE;
    endcase
    if (wr_mc) begin
      vsel_bit_nxt = hwdata[MC_VSEL];
    end
    if (wr_hc) begin
      keep_stop_nxt = hwdata[HC_KEEP_STOP];
      keep_off_nxt = hwdata[HC_KEEP_OFF_UV];
    end
    if (soft_reset) begin
      sa_bit_nxt = (cfg_r == AUXRG_CFG_SA) ? 1'b0 : sa_bit_r;
      vsel_bit_nxt = 1'b0;
      keep_stop_nxt = 1'b0;
      keep_off_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= AUXRG_CFG_NONE;
      sa_bit_r <= 1'b0;
      vsel_bit_r <= 1'b0;
      share_bit_r <= 1'b0;
      keep_stop_r <= 1'b0;
      keep_off_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      sa_bit_r <= sa_bit_nxt;
      vsel_bit_r <= vsel_bit_nxt;
      share_bit_r <= share_bit_nxt;
      keep_stop_r <= keep_stop_nxt;
      keep_off_r <= keep_off_nxt;
      fail_r <= fail_nxt;
    end
  end

  // Regulator gating, stages and flags
  always_comb begin
    want_on = 1'b0;
    case (cfg_r)
      AUXRG_CFG_SA: begin
        want_on = sa_bit_r && (sbc_mode == AUXRG_MD_NORMAL || sbc_mode == AUXRG_MD_STOP ||
                  sbc_mode == AUXRG_MD_RESTART);
      end
      AUXRG_CFG_LS: begin
        case (sbc_mode)
          AUXRG_MD_NORMAL: want_on = share_bit_r && sense.main_on;
          AUXRG_MD_STOP: want_on = share_bit_r && sense.main_on && keep_stop_r;
          AUXRG_MD_RESTART: want_on = share_bit_r && sense.main_on;
          default: want_on = 1'b0;
        endcase
      end
      default: want_on = 1'b0;
    endcase
    uv_hold_nxt = uv_hold_r;
    if (sense.battery_uv && keep_off_r) begin
      uv_hold_nxt = 1'b1;
    end else if (wr_mc || wr_hc) begin
      uv_hold_nxt = 1'b0;
    end
    drive_nxt.aux_on = want_on && !sense.battery_uv && !uv_hold_r;
    drive_nxt.vsel_1v8 = (cfg_r == AUXRG_CFG_SA) && vsel_bit_r && sense.main_3v3;
    hp_stop_nxt = hp_stop_r;
    if (sense.base_above_rise) begin
      hp_stop_nxt = 1'b1;
    end else if (sense.base_below_fall) begin
      hp_stop_nxt = 1'b0;
    end
    drive_nxt.hp_stage = drive_nxt.aux_on &&
                         ((sbc_mode != AUXRG_MD_STOP) || hp_stop_r);
    drive_nxt.lp_stage = drive_nxt.aux_on && (sbc_mode == AUXRG_MD_STOP);
    oc_flag_nxt = oc_flag_r;
    if (wr_ss && hwdata[SS_OC] && !sense.shunt_limit) begin
      oc_flag_nxt = 1'b0;
    end
    if (cfg_r == AUXRG_CFG_SA && drive_r.aux_on && sense.shunt_limit) begin
      oc_flag_nxt = 1'b1;
    end
    uv_flag_nxt = uv_flag_r;
    if (wr_ss && hwdata[SS_UV]) begin
      uv_flag_nxt = 1'b0;
    end
    if (cfg_r == AUXRG_CFG_SA && drive_r.aux_on && sense.out_uv) begin
      uv_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_hold_r <= 1'b0;
      hp_stop_r <= 1'b0;
      drive_r <= '0;
      oc_flag_r <= 1'b0;
      uv_flag_r <= 1'b0;
    end else begin
      uv_hold_r <= uv_hold_nxt;
      hp_stop_r <= hp_stop_nxt;
      drive_r <= drive_nxt;
      oc_flag_r <= oc_flag_nxt;
      uv_flag_r <= uv_flag_nxt;
    end
  end

  // Single-cycle conditions and multi-step behaviours that the properties below are built from
  sequence s_sa_vsel;
    cfg_r == AUXRG_CFG_SA && vsel_bit_r && sense.main_3v3;
  endsequence

  sequence s_sa_quiet;
    cfg_r == AUXRG_CFG_SA && !fail_r && !(wr_cs && hwdata[CS_FAIL]);
  endsequence

  sequence s_ls_change;
    cfg_r == AUXRG_CFG_LS && ((wr_mc && hwdata[MC_STANDALONE]) || (wr_hc && !hwdata[HC_SHARE]));
  endsequence

  sequence s_failsafe_held;
    (sbc_mode == AUXRG_MD_FAILSAFE) [*2];
  endsequence

  // Threshold seen, then stop mode with the regulator on: the latch needs one cycle
  sequence s_stop_rise;
    sense.base_above_rise ##1 (sbc_mode == AUXRG_MD_STOP && drive_nxt.aux_on);
  endsequence

  sequence s_stop_fall;
    (sense.base_below_fall && !sense.base_above_rise) ##1 (sbc_mode == AUXRG_MD_STOP);
  endsequence

  AST_VSEL: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sa_vsel |=> drive_r.vsel_1v8)
    else $error("1.8V select not applied");
  AST_VSEL_LS: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_LS |=> !drive_r.vsel_1v8)
    else $error("voltage select used in load sharing");
  AST_SA_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_NONE && wr_mc && hwdata[MC_STANDALONE] && sbc_mode == AUXRG_MD_NORMAL
    |=> cfg_r == AUXRG_CFG_SA)
    else $error("stand-alone enable did not lock");
  AST_LS_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_NONE && wr_hc && hwdata[HC_SHARE] && sbc_mode == AUXRG_MD_NORMAL
    |=> cfg_r == AUXRG_CFG_LS && share_bit_r)
    else $error("share enable did not lock");
  AST_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r != AUXRG_CFG_NONE |=> cfg_r == $past(cfg_r))
    else $error("locked configuration changed");
  AST_SOFT_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_reset && cfg_r != AUXRG_CFG_NONE
    |=> cfg_r == $past(cfg_r) && share_bit_r == $past(share_bit_r))
    else $error("soft reset touched the lock");
  AST_SA_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sa_quiet |=> !fail_r)
    else $error("access fail in stand-alone");
  AST_SA_SWITCH: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_SA && wr_mc && !soft_reset |=> sa_bit_r == $past(hwdata[MC_STANDALONE]))
    else $error("stand-alone switch refused");
  AST_LS_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ls_change |=> fail_r && share_bit_r && cfg_r == AUXRG_CFG_LS)
    else $error("load-sharing change not flagged");
  AST_OC_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_SA && drive_r.aux_on && sense.shunt_limit |=> oc_flag_r)
    else $error("overcurrent flag not set");
  AST_OC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    oc_flag_r && sense.shunt_limit |=> oc_flag_r)
    else $error("overcurrent flag cleared while active");
  AST_UV_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_SA && drive_r.aux_on && sense.out_uv |=> uv_flag_r)
    else $error("undervoltage flag not set");
  AST_BAT_UV: assert property (@(posedge hclk) disable iff (!hresetn)
    sense.battery_uv |=> !drive_r.aux_on)
    else $error("regulator on during battery undervoltage");
  AST_UV_RETURN: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_SA && sa_bit_r && sbc_mode == AUXRG_MD_NORMAL && !sense.battery_uv &&
    !uv_hold_r |=> drive_r.aux_on)
    else $error("regulator did not return after undervoltage");
  AST_KEEP_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    keep_off_r && sense.battery_uv |=> uv_hold_r)
    else $error("keep-off after undervoltage not held");
  AST_STOP_LS: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_LS && sbc_mode == AUXRG_MD_STOP && !keep_stop_r
    |=> !drive_r.aux_on && share_bit_r)
    else $error("sharing left on in stop mode");
  AST_FS: assert property (@(posedge hclk) disable iff (!hresetn)
    s_failsafe_held |-> !drive_r.aux_on)
    else $error("regulator on in fail-safe");
  AST_UV_LS: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_LS && !uv_flag_r |=> !uv_flag_r)
    else $error("undervoltage flag in load sharing");
  AST_OC_LS: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_LS && !oc_flag_r |=> !oc_flag_r)
    else $error("overcurrent flag in load sharing");
  AST_LS_MAIN: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r == AUXRG_CFG_LS && !sense.main_on |=> !drive_r.aux_on)
    else $error("sharing on without main regulator");
  AST_NORMAL_HP: assert property (@(posedge hclk) disable iff (!hresetn)
    sbc_mode == AUXRG_MD_NORMAL && drive_nxt.aux_on |=> drive_r.hp_stage && !drive_r.lp_stage)
    else $error("wrong stage in normal mode");
  AST_STOP_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stop_rise |=> drive_r.hp_stage)
    else $error("high-power stage not added in stop mode");
  AST_STOP_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stop_fall |=> !drive_r.hp_stage)
    else $error("high-power stage not removed in stop mode");
  AST_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[7:2] == OFF_SUP_STAT_2[7:2])
    |=> hrdata[SS_ON] == $past(drive_r.aux_on) && hrdata[SS_OC] == $past(oc_flag_r))
    else $error("supply status read wrong");
endmodule : auxrg_ctrl
`default_nettype wire

// ### tb/auxrg_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module auxrg_ctrl_bench;
  import auxreg_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic soft_reset;
  auxrg_mode_e sbc_mode;
  auxrg_sense_s sense;
  auxrg_drive_s drive;
  logic access_fail;
  int fail_count;
  int checks_done;

  assign hready = hreadyout;

  auxrg_ctrl #(.HADDR_W(32)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .soft_reset(soft_reset),
    .sbc_mode(sbc_mode), .sense(sense), .drive(drive), .access_fail(access_fail));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // Waits for an edge with hready high, bounded
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 20) begin
        chk("hready", 32'h1, {31'h0, hready});
        final_report();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask : rd_chk

  task automatic drv_chk(input logic [3:0] e);
    tick(2);
    chk("drive", {28'h0, e}, {28'h0, drive});
  endtask : drv_chk

  // Power-up: inputs idle, normal mode, main regulator on at 3.3V
  task automatic por();
    hresetn <= 1'b0;
    sbc_mode <= AUXRG_MD_NORMAL;
    sense <= 7'b1100000;
    soft_reset <= 1'b0;
    tick(10);
    hresetn <= 1'b1;
    tick(1);
  endtask : por

  task automatic t_reset_values();
    rd_chk("mode_ctrl", OFF_MODE_CTRL, RESET_WORD);
    rd_chk("hardware_control_reg", OFF_HARDWARE_CONTROL_REG, RESET_WORD);
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, RESET_WORD);
    rd_chk("cfg_stat", OFF_CFG_STAT, RESET_WORD);
    rd_chk("unmapped", 8'h10, RESET_WORD);
    wr(8'h10, 32'hffff_ffff);
    rd_chk("unmapped", 8'h10, RESET_WORD);
    drv_chk(4'h0);
    $display("test reset values done");
  endtask : t_reset_values

  task automatic t_standalone();
    wr(OFF_MODE_CTRL, 32'h1);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h1);
    drv_chk(4'b1010);
    wr(OFF_MODE_CTRL, 32'h3);
    drv_chk(4'b1110);
    wr(OFF_HARDWARE_CONTROL_REG, 32'h1);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h1);
    wr(OFF_MODE_CTRL, 32'h0);
    drv_chk(4'b0000);
    wr(OFF_MODE_CTRL, 32'h1);
    drv_chk(4'b1010);
    sense.shunt_limit <= 1'b1;
    drv_chk(4'b1010);
    wr(OFF_SUP_STAT_2, 32'h1);
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, 32'h0d);
    sense.shunt_limit <= 1'b0;
    tick(2);
    wr(OFF_SUP_STAT_2, 32'h1);
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, 32'h0c);
    sense.out_uv <= 1'b1;
    tick(2);
    sense.out_uv <= 1'b0;
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, 32'h0e);
    wr(OFF_SUP_STAT_2, 32'h2);
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, 32'h0c);
    $display("test standalone done");
  endtask : t_standalone

  task automatic t_stages_and_uv();
    sbc_mode <= AUXRG_MD_STOP;
    drv_chk(4'b1001);
    sense.base_above_rise <= 1'b1;
    tick(1);
    drv_chk(4'b1011);
    sense.base_above_rise <= 1'b0;
    sense.base_below_fall <= 1'b1;
    tick(1);
    drv_chk(4'b1001);
    sense.base_below_fall <= 1'b0;
    sbc_mode <= AUXRG_MD_NORMAL;
    sense.battery_uv <= 1'b1;
    drv_chk(4'b0000);
    sense.battery_uv <= 1'b0;
    drv_chk(4'b1010);
    wr(OFF_HARDWARE_CONTROL_REG, 32'h4);
    sense.battery_uv <= 1'b1;
    tick(2);
    sense.battery_uv <= 1'b0;
    drv_chk(4'b0000);
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, 32'h20);
    wr(OFF_MODE_CTRL, 32'h1);
    drv_chk(4'b1010);
    soft_reset <= 1'b1;
    tick(1);
    soft_reset <= 1'b0;
    drv_chk(4'b0000);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h1);
    wr(OFF_HARDWARE_CONTROL_REG, 32'h1);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h1);
    chk("access_fail", 32'h0, {31'h0, access_fail});
    $display("test stages and undervoltage done");
  endtask : t_stages_and_uv

  task automatic t_sharing();
    por();
    wr(OFF_HARDWARE_CONTROL_REG, 32'h1);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h2);
    drv_chk(4'b1010);
    wr(OFF_MODE_CTRL, 32'h2);
    drv_chk(4'b1010);
    wr(OFF_MODE_CTRL, 32'h1);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h6);
    chk("access_fail", 32'h1, {31'h0, access_fail});
    wr(OFF_CFG_STAT, 32'h4);
    wr(OFF_HARDWARE_CONTROL_REG, 32'h0);
    rd_chk("hardware_control_reg", OFF_HARDWARE_CONTROL_REG, 32'h1);
    rd_chk("cfg_stat", OFF_CFG_STAT, 32'h6);
    wr(OFF_CFG_STAT, 32'h4);
    wr(OFF_HARDWARE_CONTROL_REG, 32'h1);
    sense.shunt_limit <= 1'b1;
    sense.out_uv <= 1'b1;
    tick(3);
    rd_chk("sup_stat_2", OFF_SUP_STAT_2, 32'h0c);
    sense.shunt_limit <= 1'b0;
    sense.out_uv <= 1'b0;
    sbc_mode <= AUXRG_MD_STOP;
    drv_chk(4'b0000);
    rd_chk("hardware_control_reg", OFF_HARDWARE_CONTROL_REG, 32'h1);
    wr(OFF_HARDWARE_CONTROL_REG, 32'h3);
    drv_chk(4'b1001);
    sbc_mode <= AUXRG_MD_NORMAL;
    drv_chk(4'b1010);
    sense.main_on <= 1'b0;
    drv_chk(4'b0000);
    sense.main_on <= 1'b1;
    sbc_mode <= AUXRG_MD_FAILSAFE;
    drv_chk(4'b0000);
    sbc_mode <= AUXRG_MD_RESTART;
    drv_chk(4'b1010);
    sbc_mode <= AUXRG_MD_SLEEP;
    drv_chk(4'b0000);
    $display("test load sharing done");
  endtask : t_sharing

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    soft_reset = 1'b0;
    sbc_mode = AUXRG_MD_INIT;
    sense = 7'h00;
    fail_count = 0;
    checks_done = 0;
    por();
    t_reset_values();
    t_standalone();
    t_stages_and_uv();
    t_sharing();
    final_report();
  end
endmodule : auxrg_ctrl_bench
`default_nettype wire
